// *** rtl/pbd_pkg.sv ***
// Constants, command codes and carrier types of the background debug block.
// Assumes a single 50 MHz clock and 16-bit serial debug words.
package pbd_pkg;
	// APB register byte offsets and field positions.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] SPACE_OFS = 8'h08;
	localparam logic [7:0] BLOCK_OFS = 8'h0C;
	localparam int CTRL_TRACE = 0;
	localparam int CTRL_FLOW = 1;
	localparam int CTRL_BK_BGND = 2;
	localparam int CTRL_SHOW = 3;
	localparam int STAT_BGND = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_PRST = 2;
	localparam int STAT_PEND = 3;
	localparam int SPACE_SRC = 0;
	localparam int SPACE_DST = 4;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [2:0] SPACE_RST = 3'h0;
	// Exception vector numbers.
	localparam logic [7:0] VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_TRACE = 8'h09;
	localparam logic [7:0] VEC_LINE_A = 8'h0A;
	localparam logic [7:0] VEC_LINE_F = 8'h0B;
	localparam logic [7:0] VEC_BKPT = 8'h0C;
	localparam logic [15:0] BKPT_OPC_LO = 16'h4848;
	localparam logic [15:0] BKPT_OPC_HI = 16'h484F;
	// Peripheral reset length in clock cycles.
	localparam int RST_CYCLES = 512;
	localparam logic [8:0] RST_LAST = 9'(RST_CYCLES - 1);
	// Serial word framing and fixed answer words.
	localparam logic [3:0] LAST_BIT = 4'hF;
	localparam logic [15:0] NULL_WORD = 16'h0000;
	localparam logic [15:0] ERR_WORD = 16'hFFFF;
	// Command codes in bits 15:12 of a command word.
	localparam logic [3:0] C_NOP = 4'h0;
	localparam logic [3:0] C_RD_REG = 4'h1;
	localparam logic [3:0] C_WR_REG = 4'h2;
	localparam logic [3:0] C_RD_SYS = 4'h3;
	localparam logic [3:0] C_WR_SYS = 4'h4;
	localparam logic [3:0] C_READ = 4'h5;
	localparam logic [3:0] C_WRITE = 4'h6;
	localparam logic [3:0] C_DUMP = 4'h7;
	localparam logic [3:0] C_FILL = 4'h8;
	localparam logic [3:0] C_GO = 4'h9;
	localparam logic [3:0] C_CALL = 4'hA;
	localparam logic [3:0] C_RST = 4'hB;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	typedef enum logic [2:0] {
		OP_RD_REG, OP_WR_REG, OP_RD_SYS, OP_WR_SYS, OP_RD_MEM, OP_WR_MEM, OP_STACK_PC
	} pbd_op_t;

	typedef struct packed {
		pbd_op_t op;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0] size;
		logic [2:0] space;
	} pbd_acc_t;

	typedef enum logic [1:0] {ST_CMD, ST_OPND, ST_ACCESS} pbd_state_t;
endpackage

// *** rtl/pbd_top.sv ***
// Background debug, trace, breakpoint and pipeline tracking logic of a processor core.
// Assumes the core reports its events synchronously and answers debug accesses with an ack.
`timescale 1ns/1ps

// How it works
// - Trace exception after every completed instruction
// - Optional trace only on flow changes
// - Opcodes 4848 to 484F are breakpoint illegals
// - Illegal, A-line, F-line get distinct vectors
// - Dispatch command once all words arrived
// - Results shift out during next word
// - Pipe advance output marks pipeline advances
// - Pipe fill output marks fills and flushes
// - External breakpoint; internal only with show cycles
// - Flushed prefetch breakpoints dropped, operands acknowledged
// - Breakpoint takes vector 12 or background
// - Read and write address or data registers
// - Read and write system control registers
// - Memory read uses source space code
// - Memory write uses destination space code
// - Block dump: read then read-continue
// - Block fill: write then write-continue
// - Resume flushes pipeline, runs at PC
// - Patch stacks PC, runs patch code
// - Peripheral reset held 512 cycles
// - No-operation command changes nothing
// - Enter background on breakpoint, instruction, double fault
module pbd_top (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Core execution events
	input wire logic INSN_DONE_I,
	input wire logic INSN_FLOW_I,
	input wire logic OPCODE_VALID_I,
	input wire logic [15:0] OPCODE_I,
	input wire logic ILLEGAL_I,
	input wire logic BGND_INSN_I,
	input wire logic DOUBLE_FAULT_I,
	// Pipeline tracking
	input wire logic PIPE_ADV_I,
	input wire logic PIPE_FILL_I,
	input wire logic PIPE_FLUSH_I,
	output logic PIPE_ADVANCE_OUT_O,
	output logic PIPE_FILL_CYCLE_OUT_O,
	// Breakpoints
	input wire logic BKPT_I,
	input wire logic BKPT_PREFETCH_I,
	input wire logic BKPT_INTERNAL_I,
	input wire logic PREFETCH_EXEC_I,
	// Exception and mode outputs
	output logic EXC_REQ_O,
	output logic [7:0] EXC_VEC_O,
	output logic BGND_O,
	output logic RESUME_O,
	output logic PATCH_O,
	output logic PERIPH_RESET_O,
	// Serial debug port
	input wire logic SER_CLK_I,
	input wire logic SER_DIN_I,
	output logic SER_DOUT_O,
	// Debug access to the core
	output logic DBG_REQ_O,
	output pbd_pkg::pbd_acc_t DBG_ACC_O,
	input wire logic DBG_ACK_I,
	input wire logic [31:0] DBG_RDATA_I
);
	logic [3:0] ctrl, next_ctrl;
	logic [2:0] src_space, next_src_space, dst_space, next_dst_space;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, clr_err, apb_wr;
	logic bkpt_pend, next_bkpt_pend, next_exc_req;
	logic [7:0] next_exc_vec;
	logic bkpt_seen, bkpt_ack, trace_hit, opc_bkpt, line_a, line_f, enter_bgnd;
	pbd_pkg::pbd_state_t state, next_state;
	logic sclk_q, word_done, launch, next_bgnd, next_resume, next_patch, next_req;
	logic [3:0] bit_cnt, next_bit_cnt, cmd, next_cmd, cmd_w;
	logic [15:0] in_sh, next_in_sh, out_sh, next_out_sh, in_word, res_hi, next_res_hi;
	logic [15:0] res_lo, next_res_lo, cmd_word, next_cmd_word;
	logic [1:0] res_n, next_res_n, size_w;
	logic [2:0] left, next_left;
	logic [63:0] opnd, next_opnd;
	logic [31:0] blk_addr, next_blk_addr, step;
	logic [1:0] blk_size, next_blk_size;
	logic cmd_err, next_cmd_err, next_prst;
	logic [8:0] rst_cnt, next_rst_cnt;
	pbd_pkg::pbd_acc_t next_acc;

	// Words that still have to follow a command word.
	function automatic logic [2:0] need_words(input logic [15:0] c);
		logic [2:0] n;
		n = 3'h0;
		case (c[15:12])
			pbd_pkg::C_WR_REG, pbd_pkg::C_WR_SYS, pbd_pkg::C_READ: n = 3'h2;
			pbd_pkg::C_WRITE: n = (c[1:0] == pbd_pkg::SZ_LONG) ? 3'h4 : 3'h3;
			pbd_pkg::C_FILL: n = (c[1:0] == pbd_pkg::SZ_LONG) ? 3'h2 : 3'h1;
			default: n = 3'h0;
		endcase
		return n;
	endfunction

	// APB slave: one wait-free access phase, ready answered from a flop.
	assign apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	assign clr_err = apb_wr & (PADDR_I == pbd_pkg::STAT_OFS) & PWDATA_I[pbd_pkg::STAT_ERR];

	always_comb begin
		next_ctrl = ctrl;
		next_src_space = src_space;
		next_dst_space = dst_space;
		next_pready = PSEL_I & ~PENABLE_I;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (PSEL_I & ~PENABLE_I) begin
			case (PADDR_I)
				pbd_pkg::CTRL_OFS: next_prdata = {28'h000_0000, ctrl};
				pbd_pkg::STAT_OFS: next_prdata = {16'h0000, EXC_VEC_O, 4'h0, bkpt_pend,
					PERIPH_RESET_O, cmd_err, BGND_O};
				pbd_pkg::SPACE_OFS: next_prdata = {25'h000_0000, dst_space, 1'b0, src_space};
				pbd_pkg::BLOCK_OFS: next_prdata = blk_addr;
				default: next_pslverr = 1'b1;
			endcase
		end
		if (apb_wr & (PADDR_I == pbd_pkg::CTRL_OFS)) begin
			next_ctrl = PWDATA_I[3:0];
		end
		if (apb_wr & (PADDR_I == pbd_pkg::SPACE_OFS)) begin
			next_src_space = PWDATA_I[pbd_pkg::SPACE_SRC +: 3];
			next_dst_space = PWDATA_I[pbd_pkg::SPACE_DST +: 3];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			ctrl <= pbd_pkg::CTRL_RST;
			src_space <= pbd_pkg::SPACE_RST;
			dst_space <= pbd_pkg::SPACE_RST;
			PRDATA_O <= 32'h0000_0000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			src_space <= next_src_space;
			dst_space <= next_dst_space;
			PRDATA_O <= next_prdata;
			PREADY_O <= next_pready;
			PSLVERR_O <= next_pslverr;
		end
	end

	// Execution events. The core is halted in background, so its events are ignored there.
	assign bkpt_seen = BKPT_I & (~BKPT_INTERNAL_I | ctrl[pbd_pkg::CTRL_SHOW]);
	assign bkpt_ack = ~BGND_O & ((bkpt_seen & ~BKPT_PREFETCH_I) | (bkpt_pend & PREFETCH_EXEC_I));
	assign trace_hit = INSN_DONE_I & ctrl[pbd_pkg::CTRL_TRACE]
		& (~ctrl[pbd_pkg::CTRL_FLOW] | INSN_FLOW_I);
	assign opc_bkpt = OPCODE_I >= pbd_pkg::BKPT_OPC_LO && OPCODE_I <= pbd_pkg::BKPT_OPC_HI;
	assign line_a = OPCODE_VALID_I & (OPCODE_I[15:12] == 4'hA);
	assign line_f = OPCODE_VALID_I & (OPCODE_I[15:12] == 4'hF);
	assign enter_bgnd = ~BGND_O & ((bkpt_ack & ctrl[pbd_pkg::CTRL_BK_BGND]) | BGND_INSN_I
		| DOUBLE_FAULT_I);

	always_comb begin
		next_exc_req = 1'b0;
		next_exc_vec = EXC_VEC_O;
		// A new prefetch breakpoint wins over a flush in the same cycle.
		next_bkpt_pend = (bkpt_pend & ~PREFETCH_EXEC_I & ~PIPE_FLUSH_I)
			| (~BGND_O & bkpt_seen & BKPT_PREFETCH_I);
		if (~BGND_O & ~enter_bgnd) begin
			next_exc_req = bkpt_ack | line_f | line_a | (OPCODE_VALID_I & (ILLEGAL_I | opc_bkpt))
				| trace_hit;
			if (bkpt_ack) begin
				next_exc_vec = pbd_pkg::VEC_BKPT;
			end else if (line_f) begin
				next_exc_vec = pbd_pkg::VEC_LINE_F;
			end else if (line_a) begin
				next_exc_vec = pbd_pkg::VEC_LINE_A;
			end else if (OPCODE_VALID_I & (ILLEGAL_I | opc_bkpt)) begin
				next_exc_vec = pbd_pkg::VEC_ILLEGAL;
			end else if (trace_hit) begin
				next_exc_vec = pbd_pkg::VEC_TRACE;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			EXC_REQ_O <= 1'b0;
			EXC_VEC_O <= 8'h00;
			bkpt_pend <= 1'b0;
			PIPE_ADVANCE_OUT_O <= 1'b0;
			PIPE_FILL_CYCLE_OUT_O <= 1'b0;
		end else begin
			EXC_REQ_O <= next_exc_req;
			EXC_VEC_O <= next_exc_vec;
			bkpt_pend <= next_bkpt_pend;
			PIPE_ADVANCE_OUT_O <= PIPE_ADV_I;
			PIPE_FILL_CYCLE_OUT_O <= PIPE_FILL_I | PIPE_FLUSH_I | next_resume;
		end
	end

	// Serial command engine. Bits move MSB first on each sampled rising serial clock.
	assign in_word = {in_sh[14:0], SER_DIN_I};
	assign word_done = SER_CLK_I & ~sclk_q & (bit_cnt == pbd_pkg::LAST_BIT);
	assign SER_DOUT_O = out_sh[15];
	assign step = (blk_size == pbd_pkg::SZ_LONG) ? 32'h0000_0004 :
		(blk_size == pbd_pkg::SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_in_sh = in_sh;
		next_out_sh = out_sh;
		next_res_hi = res_hi;
		next_res_lo = res_lo;
		next_res_n = res_n;
		next_cmd = cmd;
		next_cmd_word = cmd_word;
		next_left = left;
		next_opnd = opnd;
		next_blk_addr = blk_addr;
		next_blk_size = blk_size;
		next_req = DBG_REQ_O;
		next_acc = DBG_ACC_O;
		next_bgnd = BGND_O | enter_bgnd;
		next_resume = 1'b0;
		next_patch = 1'b0;
		next_cmd_err = cmd_err & ~clr_err;
		next_prst = PERIPH_RESET_O;
		next_rst_cnt = rst_cnt;
		launch = 1'b0;
		cmd_w = cmd;
		size_w = cmd_word[1:0];
		if (PERIPH_RESET_O) begin
			next_rst_cnt = rst_cnt + 9'h001;
			next_prst = rst_cnt != pbd_pkg::RST_LAST;
		end
		if (SER_CLK_I & ~sclk_q) begin
			next_in_sh = in_word;
			next_bit_cnt = bit_cnt + 4'h1;
			next_out_sh = {out_sh[14:0], 1'b0};
		end
		if (word_done) begin
			// The pending result leaves while the next word comes in.
			next_out_sh = (res_n != 2'h0) ? res_hi : pbd_pkg::NULL_WORD;
			next_res_hi = res_lo;
			next_res_n = (res_n != 2'h0) ? res_n - 2'h1 : 2'h0;
			next_opnd = {opnd[47:0], in_word};
			if (BGND_O & state == pbd_pkg::ST_CMD) begin
				next_cmd = in_word[15:12];
				next_cmd_word = in_word;
				next_left = need_words(in_word);
				launch = need_words(in_word) == 3'h0;
				next_state = launch ? pbd_pkg::ST_CMD : pbd_pkg::ST_OPND;
				cmd_w = in_word[15:12];
				size_w = in_word[1:0];
			end else if (BGND_O & state == pbd_pkg::ST_OPND) begin
				next_left = left - 3'h1;
				launch = left == 3'h1;
				next_state = launch ? pbd_pkg::ST_CMD : pbd_pkg::ST_OPND;
			end
		end
		if (launch) begin
			next_acc.size = pbd_pkg::SZ_LONG;
			next_acc.addr = {28'h000_0000, next_cmd_word[3:0]};
			next_acc.wdata = next_opnd[31:0];
			next_acc.space = src_space;
			next_req = 1'b1;
			next_state = pbd_pkg::ST_ACCESS;
			case (cmd_w)
				pbd_pkg::C_RD_REG: next_acc.op = pbd_pkg::OP_RD_REG;
				pbd_pkg::C_WR_REG: next_acc.op = pbd_pkg::OP_WR_REG;
				pbd_pkg::C_RD_SYS: next_acc.op = pbd_pkg::OP_RD_SYS;
				pbd_pkg::C_WR_SYS: next_acc.op = pbd_pkg::OP_WR_SYS;
				pbd_pkg::C_READ, pbd_pkg::C_DUMP: begin
					next_acc.op = pbd_pkg::OP_RD_MEM;
					next_acc.space = src_space;
					if (cmd_w == pbd_pkg::C_READ) begin
						next_acc.size = size_w;
						next_acc.addr = next_opnd[31:0];
						next_blk_size = size_w;
					end else begin
						next_acc.size = blk_size;
						next_acc.addr = blk_addr + step;
					end
					next_blk_addr = next_acc.addr;
				end
				pbd_pkg::C_WRITE, pbd_pkg::C_FILL: begin
					next_acc.op = pbd_pkg::OP_WR_MEM;
					next_acc.space = dst_space;
					next_acc.size = (cmd_w == pbd_pkg::C_WRITE) ? size_w : blk_size;
					if (next_acc.size != pbd_pkg::SZ_LONG) begin
						next_acc.wdata = {16'h0000, next_opnd[15:0]};
					end
					if (cmd_w == pbd_pkg::C_FILL) begin
						next_acc.addr = blk_addr + step;
					end else if (size_w == pbd_pkg::SZ_LONG) begin
						next_acc.addr = next_opnd[63:32];
						next_blk_size = size_w;
					end else begin
						next_acc.addr = next_opnd[47:16];
						next_blk_size = size_w;
					end
					next_blk_addr = next_acc.addr;
				end
				pbd_pkg::C_CALL: next_acc.op = pbd_pkg::OP_STACK_PC;
				pbd_pkg::C_GO: begin
					next_req = 1'b0;
					next_state = pbd_pkg::ST_CMD;
					next_bgnd = 1'b0;
					next_resume = 1'b1;
				end
				pbd_pkg::C_RST: begin
					next_req = 1'b0;
					next_state = pbd_pkg::ST_CMD;
					next_prst = 1'b1;
					next_rst_cnt = 9'h000;
				end
				pbd_pkg::C_NOP: begin
					next_req = 1'b0;
					next_state = pbd_pkg::ST_CMD;
				end
				default: begin
					next_req = 1'b0;
					next_state = pbd_pkg::ST_CMD;
					next_cmd_err = 1'b1;
					next_out_sh = pbd_pkg::ERR_WORD;
					next_res_n = 2'h0;
				end
			endcase
		end
		if (state == pbd_pkg::ST_ACCESS & DBG_ACK_I) begin
			next_req = 1'b0;
			next_state = pbd_pkg::ST_CMD;
			if (DBG_ACC_O.op == pbd_pkg::OP_STACK_PC) begin
				next_bgnd = 1'b0;
				next_patch = 1'b1;
			end else if (DBG_ACC_O.op inside {pbd_pkg::OP_RD_REG, pbd_pkg::OP_RD_SYS,
				pbd_pkg::OP_RD_MEM}) begin
				if (DBG_ACC_O.size == pbd_pkg::SZ_LONG) begin
					next_res_hi = DBG_RDATA_I[31:16];
					next_res_lo = DBG_RDATA_I[15:0];
					next_res_n = 2'h2;
				end else begin
					next_res_hi = (DBG_ACC_O.size == pbd_pkg::SZ_BYTE) ?
						{8'h00, DBG_RDATA_I[7:0]} : DBG_RDATA_I[15:0];
					next_res_n = 2'h1;
				end
				// A result arriving between words goes out on the very next word.
				if (bit_cnt == 4'h0 && !(SER_CLK_I & ~sclk_q)) begin
					next_out_sh = next_res_hi;
					next_res_hi = next_res_lo;
					next_res_n = next_res_n - 2'h1;
				end
			end
		end
		if (~next_bgnd) begin
			next_state = pbd_pkg::ST_CMD;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			state <= pbd_pkg::ST_CMD;
			sclk_q <= 1'b0;
			bit_cnt <= 4'h0;
			in_sh <= 16'h0000;
			out_sh <= 16'h0000;
			res_hi <= 16'h0000;
			res_lo <= 16'h0000;
			res_n <= 2'h0;
			cmd <= 4'h0;
			cmd_word <= 16'h0000;
			left <= 3'h0;
			opnd <= 64'h0000_0000_0000_0000;
			blk_addr <= 32'h0000_0000;
			blk_size <= 2'h0;
			DBG_REQ_O <= 1'b0;
			DBG_ACC_O <= '0;
			BGND_O <= 1'b0;
			RESUME_O <= 1'b0;
			PATCH_O <= 1'b0;
			cmd_err <= 1'b0;
			PERIPH_RESET_O <= 1'b0;
			rst_cnt <= 9'h000;
		end else begin
			state <= next_state;
			sclk_q <= SER_CLK_I;
			bit_cnt <= next_bit_cnt;
			in_sh <= next_in_sh;
			out_sh <= next_out_sh;
			res_hi <= next_res_hi;
			res_lo <= next_res_lo;
			res_n <= next_res_n;
			cmd <= next_cmd;
			cmd_word <= next_cmd_word;
			left <= next_left;
			opnd <= next_opnd;
			blk_addr <= next_blk_addr;
			blk_size <= next_blk_size;
			DBG_REQ_O <= next_req;
			DBG_ACC_O <= next_acc;
			BGND_O <= next_bgnd;
			RESUME_O <= next_resume;
			PATCH_O <= next_patch;
			cmd_err <= next_cmd_err;
			PERIPH_RESET_O <= next_prst;
			rst_cnt <= next_rst_cnt;
		end
	end

	// Checks. Helper counter measures how long the peripheral reset stays high.
	logic [9:0] prst_len;
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			prst_len <= 10'h000;
		end else begin
			prst_len <= PERIPH_RESET_O ? prst_len + 10'h001 : 10'h000;
		end
	end

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);

	chk_trace_every: assert property (
		trace_hit & ~ctrl[pbd_pkg::CTRL_FLOW] & ~BGND_O & ~enter_bgnd & ~bkpt_ack & ~OPCODE_VALID_I
		|=> EXC_REQ_O && EXC_VEC_O == 8'h09) else $error("trace exception missing");
	chk_flow_only: assert property (
		ctrl[pbd_pkg::CTRL_FLOW] & INSN_DONE_I & ~INSN_FLOW_I & ~bkpt_ack & ~OPCODE_VALID_I
		|=> !EXC_REQ_O) else $error("flow-only trace fired on plain instruction");
	chk_bkpt_opcode: assert property (
		OPCODE_VALID_I && OPCODE_I == 16'h484C && ~bkpt_ack && ~BGND_O && ~enter_bgnd
		|=> EXC_REQ_O && EXC_VEC_O == 8'h04) else $error("breakpoint opcode not illegal");
	chk_line_f_vec: assert property (
		line_f & ~bkpt_ack & ~BGND_O & ~enter_bgnd |=> EXC_VEC_O == 8'h0B)
		else $error("F-line vector wrong");
	chk_bkpt_route: assert property (
		bkpt_ack |=> (EXC_REQ_O && EXC_VEC_O == 8'h0C) || BGND_O)
		else $error("breakpoint neither trapped nor entered background");
	chk_flush_drop: assert property (
		bkpt_pend & PIPE_FLUSH_I & ~PREFETCH_EXEC_I & ~BKPT_I |=> !bkpt_pend ##1 !EXC_REQ_O || EXC_VEC_O != 8'h0C || $past(bkpt_ack))
		else $error("flushed prefetch breakpoint kept");
	chk_fill_flush: assert property (
		PIPE_FLUSH_I |=> PIPE_FILL_CYCLE_OUT_O) else $error("flush not shown on fill output");
	chk_rst_length: assert property (
		$fell(PERIPH_RESET_O) |-> prst_len == 10'd512) else $error("peripheral reset length wrong");
	chk_blk_advance: assert property (
		launch && cmd_w == pbd_pkg::C_DUMP |=> DBG_ACC_O.addr == $past(blk_addr) + $past(step) ##0 DBG_REQ_O)
		else $error("block address not advanced");
	chk_bad_cmd: assert property (
		launch && cmd_w > pbd_pkg::C_RST |=> cmd_err && !DBG_REQ_O && BGND_O)
		else $error("unknown command not flagged");
	chk_resume_exit: assert property (
		launch && cmd_w == pbd_pkg::C_GO |=> RESUME_O && !BGND_O && PIPE_FILL_CYCLE_OUT_O)
		else $error("resume did not leave background");

	cov_trace: cover property (EXC_REQ_O && EXC_VEC_O == 8'h09);
	cov_bgnd_entry: cover property ($rose(BGND_O));
	cov_dump: cover property (launch && cmd_w == pbd_pkg::C_DUMP ##[1:20] DBG_ACK_I);
	cov_prst: cover property ($fell(PERIPH_RESET_O));
endmodule

// *** tb/pbd_host.sv ***
// Serial debug host model: shifts 16-bit words MSB first and collects the answer word.
// Assumes the device samples the serial clock with the system clock.
`timescale 1ns/1ps
module pbd_host (
	// Clock
	input wire logic clk_i,
	// Serial lines
	input wire logic dout_i,
	output logic sclk_o,
	output logic din_o
);
	initial begin
		sclk_o = 1'b0;
		din_o = 1'b0;
	end
	// Each level lasts at least two system clocks, so the device never misses an edge.
	// Between words the clock stands low and the data line shows the inverse of its last bit.
	task automatic word(input logic [15:0] w, output logic [15:0] r);
		for (int i = 15; i >= 0; i--) begin
			@(posedge clk_i);
			sclk_o <= 1'b0;
			din_o <= w[i];
			repeat (2) @(posedge clk_i);
			#1;
			r[i] = dout_i;
			@(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
		@(posedge clk_i);
		sclk_o <= 1'b0;
		din_o <= ~w[0];
	endtask
endmodule

// *** tb/test_processor_background_debug.sv ***
// Self-checking bench of the background debug block.
// Assumes a responsive core model here and the serial host model beside it.
`timescale 1ns/1ps
module test_processor_background_debug;
	logic MCLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
	logic INSN_DONE_I, INSN_FLOW_I, OPCODE_VALID_I, ILLEGAL_I, BGND_INSN_I, BKPT_I;
	logic PIPE_ADV_I, PIPE_FILL_I, PIPE_ADVANCE_OUT_O, PIPE_FILL_CYCLE_OUT_O, EXC_REQ_O;
	logic BGND_O, RESUME_O, PATCH_O, PERIPH_RESET_O, SER_CLK_I, SER_DIN_I, SER_DOUT_O;
	logic DBG_REQ_O, DBG_ACK_I, pa, pf, rd, e;
	logic DOUBLE_FAULT_I, PIPE_FLUSH_I, BKPT_PREFETCH_I, BKPT_INTERNAL_I, PREFETCH_EXEC_I, fq, fx;
	logic [3:0] xs;
	logic [7:0] PADDR_I, EXC_VEC_O;
	logic [15:0] OPCODE_I, rx;
	logic [31:0] PWDATA_I, PRDATA_O, DBG_RDATA_I, got, r, a, d;
	pbd_pkg::pbd_acc_t DBG_ACC_O, acc;
	int seed = 98142;
	int fail_count = 0;
	int n_tests = 0;
	int nack = 0;
	int nrst = 0;
	int nres = 0;
	int npat = 0;
	int n;
	pbd_top pbd_top_i (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
		.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
		.INSN_DONE_I(INSN_DONE_I), .INSN_FLOW_I(INSN_FLOW_I), .OPCODE_VALID_I(OPCODE_VALID_I),
		.OPCODE_I(OPCODE_I), .ILLEGAL_I(ILLEGAL_I), .BGND_INSN_I(BGND_INSN_I),
		.DOUBLE_FAULT_I(DOUBLE_FAULT_I), .PIPE_ADV_I(PIPE_ADV_I), .PIPE_FILL_I(PIPE_FILL_I),
		.PIPE_FLUSH_I(PIPE_FLUSH_I), .PIPE_ADVANCE_OUT_O(PIPE_ADVANCE_OUT_O),
		.PIPE_FILL_CYCLE_OUT_O(PIPE_FILL_CYCLE_OUT_O), .BKPT_I(BKPT_I),
		.BKPT_PREFETCH_I(BKPT_PREFETCH_I), .BKPT_INTERNAL_I(BKPT_INTERNAL_I),
		.PREFETCH_EXEC_I(PREFETCH_EXEC_I),
		.EXC_REQ_O(EXC_REQ_O), .EXC_VEC_O(EXC_VEC_O), .BGND_O(BGND_O), .RESUME_O(RESUME_O),
		.PATCH_O(PATCH_O), .PERIPH_RESET_O(PERIPH_RESET_O), .SER_CLK_I(SER_CLK_I),
		.SER_DIN_I(SER_DIN_I), .SER_DOUT_O(SER_DOUT_O), .DBG_REQ_O(DBG_REQ_O),
		.DBG_ACC_O(DBG_ACC_O), .DBG_ACK_I(DBG_ACK_I), .DBG_RDATA_I(DBG_RDATA_I));
	pbd_host pbd_host_i (.clk_i(MCLK_I), .dout_i(SER_DOUT_O), .sclk_o(SER_CLK_I),
		.din_o(SER_DIN_I));
	initial begin
		MCLK_I = 1'b0;
		forever #10 MCLK_I = ~MCLK_I;
	end
	task chk(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int k;
		@(posedge MCLK_I);
		PSEL_I <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I <= w;
		PADDR_I <= ad;
		PWDATA_I <= wd;
		@(posedge MCLK_I);
		PENABLE_I <= 1'b1;
		k = 0;
		do begin
			@(posedge MCLK_I);
			k++;
		end while (PREADY_O !== 1'b1 && k < 20);
		r = PRDATA_O;
		e = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		chk(PREADY_O === 1'b1, "apb ready");
	endtask
	task ev(input logic [5:0] s, input logic [15:0] op, input logic [7:0] v);
		@(posedge MCLK_I);
		{BGND_INSN_I, INSN_DONE_I, INSN_FLOW_I, OPCODE_VALID_I, ILLEGAL_I, BKPT_I} <= s;
		{DOUBLE_FAULT_I, BKPT_INTERNAL_I, BKPT_PREFETCH_I, PREFETCH_EXEC_I} <= xs;
		xs = 4'h0;
		OPCODE_I <= op;
		@(posedge MCLK_I);
		{BGND_INSN_I, INSN_DONE_I, INSN_FLOW_I, OPCODE_VALID_I, ILLEGAL_I, BKPT_I} <= 6'h00;
		{DOUBLE_FAULT_I, BKPT_INTERNAL_I, BKPT_PREFETCH_I, PREFETCH_EXEC_I} <= 4'h0;
		#1;
		chk(EXC_REQ_O === (v != 8'h00) && (v == 8'h00 || EXC_VEC_O === v), "exception");
	endtask
	task sw(input logic [15:0] w);
		pbd_host_i.word(w, rx);
	endtask
	task waitack(input pbd_pkg::pbd_op_t op);
		int k0;
		int k;
		k0 = nack;
		k = 0;
		while (nack == k0 && k < 300) begin
			@(posedge MCLK_I);
			#1;
			k++;
		end
		chk(nack != k0 && acc.op === op, "core access");
	endtask
	// The core answers after a random wait and is checked for pipeline tracking every cycle.
	always @(posedge MCLK_I) begin
		rd <= RESET_I;
		if (!rd && !RESET_I) begin
			chk(PIPE_ADVANCE_OUT_O === pa, "pipe advance");
			chk(PIPE_FILL_CYCLE_OUT_O === (pf | RESUME_O), "pipe fill");
		end
		pa <= PIPE_ADV_I;
		pf <= PIPE_FILL_I | PIPE_FLUSH_I;
		PIPE_ADV_I <= !RESET_I && !rd && 1'($random(seed));
		PIPE_FILL_I <= !RESET_I && !rd && 1'($random(seed));
		PIPE_FLUSH_I <= fx | (!fq && !RESET_I && !rd && 1'($random(seed)));
		DBG_ACK_I <= !RESET_I && DBG_REQ_O && !DBG_ACK_I && 1'($random(seed));
		DBG_RDATA_I <= $random(seed);
		if (DBG_REQ_O && DBG_ACK_I) begin
			got <= DBG_RDATA_I;
			acc <= DBG_ACC_O;
			nack <= nack + 1;
		end
		if (PERIPH_RESET_O) nrst <= nrst + 1;
		if (RESUME_O) nres <= nres + 1;
		if (PATCH_O) npat <= npat + 1;
	end
	initial begin
		repeat (20000) @(posedge MCLK_I);
		fail_count++;
		results();
	end
	initial begin
		RESET_I = 1'b1;
		{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, OPCODE_I, DBG_ACK_I} = '0;
		{BGND_INSN_I, INSN_DONE_I, INSN_FLOW_I, OPCODE_VALID_I, ILLEGAL_I, BKPT_I} = 6'h00;
		{PIPE_ADV_I, PIPE_FILL_I, DBG_RDATA_I} = '0;
		{DOUBLE_FAULT_I, BKPT_INTERNAL_I, BKPT_PREFETCH_I, PREFETCH_EXEC_I, fq, fx, xs} = '0;
		repeat (5) @(posedge MCLK_I);
		RESET_I <= 1'b0;
		apb(1'b0, pbd_pkg::CTRL_OFS, 32'h0000_0000);
		chk(r === 32'h0000_0000 && e === 1'b0, "control reset");
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(e === 1'b1 && r === 32'h0000_0000, "unmapped");
		apb(1'b1, pbd_pkg::SPACE_OFS, 32'h0000_0053);
		$display("test apb done");
		apb(1'b1, pbd_pkg::CTRL_OFS, 32'h0000_0001);
		ev(6'b010000, 16'h0000, pbd_pkg::VEC_TRACE);
		apb(1'b1, pbd_pkg::CTRL_OFS, 32'h0000_0003);
		ev(6'b010000, 16'h0000, 8'h00);
		ev(6'b011000, 16'h0000, pbd_pkg::VEC_TRACE);
		apb(1'b1, pbd_pkg::CTRL_OFS, 32'h0000_0000);
		for (int k = 0; k < 8; k++) ev(6'b000100, 16'h4848 + 16'(k), pbd_pkg::VEC_ILLEGAL);
		ev(6'b000110, 16'h0001, pbd_pkg::VEC_ILLEGAL);
		ev(6'b000100, 16'hF000 | 16'($random(seed) & 32'hFFF), pbd_pkg::VEC_LINE_F);
		ev(6'b000100, 16'hA000 | 16'($random(seed) & 32'hFFF), pbd_pkg::VEC_LINE_A);
		ev(6'b000001, 16'h0000, pbd_pkg::VEC_BKPT);
		fq = 1'b1;
		xs = 4'b0010;
		ev(6'b000001, 16'h0000, 8'h00);
		xs = 4'b0001;
		ev(6'b000000, 16'h0000, pbd_pkg::VEC_BKPT);
		xs = 4'b0010;
		ev(6'b000001, 16'h0000, 8'h00);
		@(posedge MCLK_I);
		fx <= 1'b1;
		@(posedge MCLK_I);
		fx <= 1'b0;
		xs = 4'b0001;
		ev(6'b000000, 16'h0000, 8'h00);
		fq = 1'b0;
		xs = 4'b0100;
		ev(6'b000001, 16'h0000, 8'h00);
		apb(1'b1, pbd_pkg::CTRL_OFS, 32'h0000_0008);
		xs = 4'b0100;
		ev(6'b000001, 16'h0000, pbd_pkg::VEC_BKPT);
		apb(1'b1, pbd_pkg::CTRL_OFS, 32'h0000_0004);
		ev(6'b000001, 16'h0000, 8'h00);
		chk(BGND_O === 1'b1, "breakpoint to background");
		$display("test events done");
		sw(16'hC000);
		sw(16'h0000);
		chk(rx === pbd_pkg::ERR_WORD, "unknown command");
		apb(1'b0, pbd_pkg::STAT_OFS, 32'h0000_0000);
		chk(r[1:0] === 2'b11, "error flag");
		a = $random(seed) & 32'hFFFF_FFFC;
		d = $random(seed);
		sw(16'h5002);
		sw(a[31:16]);
		sw(a[15:0]);
		waitack(pbd_pkg::OP_RD_MEM);
		chk(acc.addr === a && acc.space === 3'd3 && acc.size === 2'h2, "read access");
		sw(16'h0000);
		chk(rx === got[31:16], "read high");
		sw(16'h0000);
		chk(rx === got[15:0], "read low");
		sw(16'h7002);
		waitack(pbd_pkg::OP_RD_MEM);
		chk(acc.addr === a + 32'd4, "dump address");
		sw(16'h0000);
		sw(16'h0000);
		chk(rx === got[15:0], "dump low");
		sw(16'h6001);
		sw(a[31:16]);
		sw(a[15:0]);
		sw(d[15:0]);
		waitack(pbd_pkg::OP_WR_MEM);
		chk(acc.addr === a && acc.space === 3'd5 && acc.wdata[15:0] === d[15:0], "write");
		sw(16'h8001);
		sw(d[31:16]);
		waitack(pbd_pkg::OP_WR_MEM);
		chk(acc.addr === a + 32'd2 && acc.wdata[15:0] === d[31:16], "fill");
		sw(16'h100B);
		waitack(pbd_pkg::OP_RD_REG);
		sw(16'h0000);
		sw(16'h0000);
		chk(rx === got[15:0], "register low");
		sw(16'h3004);
		waitack(pbd_pkg::OP_RD_SYS);
		$display("test serial done");
		n = nack;
		sw(16'h0000);
		repeat (10) @(posedge MCLK_I);
		chk(nack == n && BGND_O === 1'b1, "no operation");
		n = nrst;
		sw(16'hB000);
		repeat (600) @(posedge MCLK_I);
		chk(nrst - n == 512 && BGND_O === 1'b1, "peripheral reset");
		sw(16'h9000);
		repeat (4) @(posedge MCLK_I);
		chk(BGND_O === 1'b0 && nres == 1, "resume");
		ev(6'b100000, 16'h0000, 8'h00);
		chk(BGND_O === 1'b1, "background instruction");
		sw(16'hA000);
		waitack(pbd_pkg::OP_STACK_PC);
		repeat (4) @(posedge MCLK_I);
		chk(BGND_O === 1'b0 && npat == 1, "patch");
		xs = 4'b1000;
		ev(6'b000000, 16'h0000, 8'h00);
		chk(BGND_O === 1'b1, "double fault");
		$display("test control done");
		results();
	end
endmodule
